// ==== rtl/halfword_mac_map.vh ====
// Field positions, opcodes and condition codes for the halfword multiply-accumulate datapath
`ifndef HALFWORD_MAC_MAP_VH
`define HALFWORD_MAC_MAP_VH
`define OPC_HI          27
`define OPC_LO          20
`define OPC_LONG        8'h14
`define OPC_WORD        8'h12
`define BIT_MULFLAG     7
`define BIT_XSEL        5
`define BIT_YSEL        6
`define BIT_MBZ         4
`define COND_HI         31
`define COND_LO         28
`define ACCHI_HI        19
`define ACCHI_LO        16
`define ACCLO_HI        15
`define ACCLO_LO        12
`define SRC2_HI         11
`define SRC2_LO         8
`define SRC1_HI         3
`define SRC1_LO         0
`define COND_EQ         4'h0
`define COND_NE         4'h1
`define COND_CS         4'h2
`define COND_CC         4'h3
`define COND_MI         4'h4
`define COND_PL         4'h5
`define COND_VS         4'h6
`define COND_VC         4'h7
`define COND_HI_C       4'h8
`define COND_LS         4'h9
`define COND_GE         4'ha
`define COND_LT         4'hb
`define COND_GT         4'hc
`define COND_LE         4'hd
`define COND_AL         4'he
`define PROD_TOP        47
`define PROD_BOT        16
`define FLAG_N          3
`define FLAG_Z          2
`define FLAG_C          1
`define FLAG_V          0
`define HALF_HI_TOP     31
`define HALF_HI_BOT     16
`define HALF_LO_TOP     15
`define HALF_LO_BOT     0
`define SIGN_BIT        31
`define LSUM_HI_TOP     63
`define LSUM_HI_BOT     32
`define LSUM_LO_TOP     31
`define LSUM_LO_BOT     0
`define RST_BIT         1'b0
`define RST_IDX         4'h0
`define RST_WORD        32'h0000_0000
`endif

// ==== rtl/halfword_mac_accumulate.v ====
// Execution datapath for the two signed halfword multiply-accumulate instructions
`timescale 1ns/1ps
`default_nettype none
`include "halfword_mac_map.vh"

// Contract
// - The long halfword MAC is decoded from bits 27:20 = 0x14, bit 7 = 1 and bit 4 = 0, with register fields at 19:16, 15:12, 11:8 and 3:0.
// - The long form's first operand is the sign-extended low half of the first source when bit 5 is 0, else the upper half.
// - In both forms the second operand is the sign-extended low half of the second source when bit 6 is 0, else the upper half.
// - The long form adds the 16x16 signed product to the 64-bit high:low accumulator pair and writes the sum back to the pair.
// - The long form orders operands low acc, high acc, first source, second source and runs only when its condition field passes.
// - The word form adds bits 47:16 of the 48-bit signed product of the first source and the halfword to the accumulate register.
// - The word form detects signed 32-bit overflow of that accumulation.
module halfword_mac_accumulate (
    input  wire        ref_clk,        // Core clock
    input  wire        nrst,           // Synchronous reset, active low
    input  wire        instValid,      // Instruction word presented this cycle
    input  wire [31:0] instWord,       // Instruction word
    input  wire [3:0]  nzcvIn,         // Current condition flags N,Z,C,V
    input  wire        satIn,          // Current sticky saturation flag
    input  wire [31:0] firstSourceReg, // Value of first source register
    input  wire [31:0] secondSourceReg,// Value of second source register
    input  wire [31:0] accumulateReg,  // Value of accumulate register (word form)
    input  wire [31:0] accHighReg,     // Value of high accumulator register (long form)
    input  wire [31:0] accLowReg,      // Value of low accumulator register (long form)
    output wire [3:0]  firstSrcIdx,    // Register index of first source
    output wire [3:0]  secondSrcIdx,   // Register index of second source
    output wire [3:0]  accHighIdx,     // Long form high acc index / word form destination
    output wire [3:0]  accLowIdx,      // Long form low acc index / word form accumulate index
    output wire        isLongMac,      // Decoded long halfword MAC
    output wire        isWordMac,      // Decoded word-by-halfword MAC
    output reg         wrLow_q,        // Write resLow_q to register wrLowIdx_q
    output reg         wrHigh_q,       // Write resHigh_q to register wrHighIdx_q
    output reg  [3:0]  wrLowIdx_q,     // Destination index for low result
    output reg  [3:0]  wrHighIdx_q,    // Destination index for high result
    output reg  [31:0] resLow_q,       // Low result word
    output reg  [31:0] resHigh_q,      // High result word (word form result too)
    output reg         satOut_q,       // Updated sticky saturation flag
    output reg         satWr_q,        // Saturation flag write strobe
    output reg         overflow_q,     // Word form overflow seen this instruction
    output wire [3:0]  nzcvOut,        // Condition flags, always passed through unchanged
    output wire        excReq          // Exception request, never raised
);

    // Instruction decode: opcode field and the format bits shared by both forms
    wire [7:0]  opc;
    wire        fmtOk;
    assign opc       = instWord[`OPC_HI:`OPC_LO];
    assign fmtOk     = instWord[`BIT_MULFLAG] & ~instWord[`BIT_MBZ];
    assign isLongMac = (opc == `OPC_LONG) & fmtOk;
    // Word form has bit 5 clear as part of its encoding
    assign isWordMac = (opc == `OPC_WORD) & fmtOk & ~instWord[`BIT_XSEL];

    // Register fields go straight out so the register file reads in the same cycle
    assign accHighIdx   = instWord[`ACCHI_HI:`ACCHI_LO];
    assign accLowIdx    = instWord[`ACCLO_HI:`ACCLO_LO];
    assign secondSrcIdx = instWord[`SRC2_HI:`SRC2_LO];
    assign firstSrcIdx  = instWord[`SRC1_HI:`SRC1_LO];

    // Condition evaluation; the reserved never-code is treated as failing
    wire [3:0]  condField;
    wire        flagN;
    wire        flagZ;
    wire        flagC;
    wire        flagV;
    reg         condPass;
    assign condField = instWord[`COND_HI:`COND_LO];
    assign flagN     = nzcvIn[`FLAG_N];
    assign flagZ     = nzcvIn[`FLAG_Z];
    assign flagC     = nzcvIn[`FLAG_C];
    assign flagV     = nzcvIn[`FLAG_V];

    always @* begin
        case (condField)
            `COND_EQ:   condPass = flagZ;
            `COND_NE:   condPass = ~flagZ;
            `COND_CS:   condPass = flagC;
            `COND_CC:   condPass = ~flagC;
            `COND_MI:   condPass = flagN;
            `COND_PL:   condPass = ~flagN;
            `COND_VS:   condPass = flagV;
            `COND_VC:   condPass = ~flagV;
            `COND_HI_C: condPass = flagC & ~flagZ;
            `COND_LS:   condPass = ~flagC | flagZ;
            `COND_GE:   condPass = (flagN == flagV);
            `COND_LT:   condPass = (flagN != flagV);
            `COND_GT:   condPass = ~flagZ & (flagN == flagV);
            `COND_LE:   condPass = flagZ | (flagN != flagV);
            `COND_AL:   condPass = 1'b1;
            default:    condPass = 1'b0;
        endcase
    end


    // Halfword operand selection, one entry per multiplier operand:
    // entry 0 reads the first source under bit 5, entry 1 the second under bit 6
    wire [31:0] selWord [0:1];
    wire        selHigh [0:1];
    wire [15:0] selHalf [0:1];
    assign selWord[0] = firstSourceReg;
    assign selWord[1] = secondSourceReg;
    assign selHigh[0] = instWord[`BIT_XSEL];
    assign selHigh[1] = instWord[`BIT_YSEL];
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_half
            assign selHalf[gi] = selHigh[gi] ? selWord[gi][`HALF_HI_TOP:`HALF_HI_BOT]
                                             : selWord[gi][`HALF_LO_TOP:`HALF_LO_BOT];
        end
    endgenerate

    wire signed [15:0] op1;
    wire signed [15:0] op2;
    assign op1 = selHalf[0];
    assign op2 = selHalf[1];

    // Long form: 16x16 product sign-extended into the 64-bit pair sum
    wire signed [31:0] prodShort;
    wire        [63:0] prodShortExt;
    wire        [63:0] accPair;
    wire        [63:0] longSum;
    assign prodShort    = op1 * op2;
    assign prodShortExt = {{32{prodShort[`SIGN_BIT]}}, prodShort};
    assign accPair      = {accHighReg, accLowReg};
    assign longSum      = accPair + prodShortExt;

    // Word form: 32x16 product, only the top 32 of its 48 bits are kept
    // The low 16 product bits are dropped, not rounded
    wire signed [31:0] srcWord;
    wire signed [47:0] prodWide;
    wire        [31:0] prodTop;
    wire        [31:0] wordSum;
    assign srcWord  = firstSourceReg;
    assign prodWide = srcWord * op2;
    assign prodTop  = prodWide[`PROD_TOP:`PROD_BOT];
    assign wordSum  = accumulateReg + prodTop;

    // Signed overflow: equal operand signs, result sign differs from them
    wire        accSign;
    wire        prodSign;
    wire        sumSign;
    wire        ovf;
    assign accSign  = accumulateReg[`SIGN_BIT];
    assign prodSign = prodTop[`SIGN_BIT];
    assign sumSign  = wordSum[`SIGN_BIT];
    assign ovf      = (accSign == prodSign) & (sumSign != accSign);

    // Only the strobes and overflow_q are gated by the condition; results update every cycle
    // and carry meaning only while a strobe stands
    wire        fire;
    assign fire = instValid & condPass;

    // No forwarding: an instruction issued right behind reads the old register
    // value, so the surrounding pipeline has to stall or forward
    reg         wrLow_d;
    reg         wrHigh_d;
    reg         satWr_d;
    reg         overflow_d;
    reg  [3:0]  wrLowIdx_d;
    reg  [3:0]  wrHighIdx_d;
    reg  [31:0] resLow_d;
    reg  [31:0] resHigh_d;
    reg         satOut_d;
    always @* begin
        wrLow_d     = fire & isLongMac;
        wrHigh_d    = fire & (isLongMac | isWordMac);
        satWr_d     = fire & isWordMac;
        overflow_d  = fire & isWordMac & ovf;
        wrLowIdx_d  = accLowIdx;
        wrHighIdx_d = accHighIdx;
        resLow_d    = longSum[`LSUM_LO_TOP:`LSUM_LO_BOT];
        resHigh_d   = isWordMac ? wordSum : longSum[`LSUM_HI_TOP:`LSUM_HI_BOT];
        // Sticky: OR keeps a prior set flag, never clears it
        satOut_d    = satIn | (isWordMac & ovf);
    end

    // Write strobes and the overflow flag
    always @(posedge ref_clk) begin
        if (!nrst) begin
            wrLow_q    <= `RST_BIT;
            wrHigh_q   <= `RST_BIT;
            satWr_q    <= `RST_BIT;
            overflow_q <= `RST_BIT;
        end else begin
            wrLow_q    <= wrLow_d;
            wrHigh_q   <= wrHigh_d;
            satWr_q    <= satWr_d;
            overflow_q <= overflow_d;
        end
    end

    // Destination indices, result words and the new saturation flag
    always @(posedge ref_clk) begin
        if (!nrst) begin
            wrLowIdx_q  <= `RST_IDX;
            wrHighIdx_q <= `RST_IDX;
            resLow_q    <= `RST_WORD;
            resHigh_q   <= `RST_WORD;
            satOut_q    <= `RST_BIT;
        end else begin
            wrLowIdx_q  <= wrLowIdx_d;
            wrHighIdx_q <= wrHighIdx_d;
            resLow_q    <= resLow_d;
            resHigh_q   <= resHigh_d;
            satOut_q    <= satOut_d;
        end
    end

    // Condition flags pass straight through; neither form may touch them
    assign nzcvOut = nzcvIn;
    assign excReq  = 1'b0;

endmodule
`default_nettype wire

// ==== tb/mac_props.sv ====
// Assertions on the halfword multiply-accumulate ports
`timescale 1ns/1ps
`default_nettype none
module mac_props (
    input wire logic        ref_clk,         // Clock
    input wire logic        nrst,            // Reset
    input wire logic        instValid,       // Request
    input wire logic [31:0] instWord,        // Instruction
    input wire logic [3:0]  nzcvIn,          // Flags in
    input wire logic        satIn,           // Q in
    input wire logic [31:0] firstSourceReg,  // Operand
    input wire logic [31:0] secondSourceReg, // Operand
    input wire logic [31:0] accumulateReg,   // Operand
    input wire logic [31:0] accHighReg,      // Operand
    input wire logic [31:0] accLowReg,       // Operand
    input wire logic        wrLow_q,         // Strobe
    input wire logic        wrHigh_q,        // Strobe
    input wire logic [31:0] resLow_q,        // Result
    input wire logic [31:0] resHigh_q,       // Result
    input wire logic        satOut_q,        // Q out
    input wire logic        satWr_q,         // Strobe
    input wire logic        overflow_q,      // Overflow
    input wire logic [3:0]  nzcvOut,         // Flags out
    input wire logic        excReq           // Exception
);
    // Decode is rebuilt here so a wrong opcode compare in the design shows up
    wire               run  = instValid && instWord[31:28] == 4'he;
    wire               lng  = run && instWord[27:20] == 8'h14 && instWord[7] && !instWord[4];
    wire               wrd  = run && instWord[27:20] == 8'h12 && instWord[7:4] == {1'b1, instWord[6], 2'b00};
    wire        [15:0] op1  = instWord[5] ? firstSourceReg[31:16] : firstSourceReg[15:0];
    wire        [15:0] op2  = instWord[6] ? secondSourceReg[31:16] : secondSourceReg[15:0];
    wire signed [31:0] p16  = $signed(op1) * $signed(op2);
    wire signed [47:0] p48  = $signed(firstSourceReg) * $signed(op2);
    wire        [63:0] sumL = {accHighReg, accLowReg} + {{32{p16[31]}}, p16};
    wire        [32:0] sumW = {accumulateReg[31], accumulateReg} + {p48[47], p48[47:16]};
    wire               ovf  = sumW[32] != sumW[31];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_long_write: assert property (lng |=> wrLow_q && wrHigh_q)
        else $error("long form not written");
    a_long_sum: assert property (lng |=> {resHigh_q, resLow_q} == $past(sumL))
        else $error("long form sum wrong");
    a_word_sum: assert property (wrd |=> wrHigh_q && !wrLow_q && resHigh_q == $past(sumW[31:0]))
        else $error("word form sum wrong");
    a_word_ovf: assert property (wrd |=> satWr_q && overflow_q == $past(ovf))
        else $error("word form overflow wrong");
    a_sat_sticky: assert property (wrd |=> satOut_q == ($past(satIn) | $past(ovf)))
        else $error("saturation flag wrong");
    a_cond_never: assert property (instValid && instWord[31:28] == 4'hf |=> !wrHigh_q && !wrLow_q)
        else $error("never condition executed");
    a_bad_form: assert property (instValid && instWord[4] |=> !wrHigh_q && !satWr_q)
        else $error("bit four set but executed");
    a_flags_kept: assert property (nzcvOut == nzcvIn && !excReq)
        else $error("flags changed or exception raised");
endmodule
`default_nettype wire

// ==== tb/regfile_model.sv ====
// Register file model feeding operand values by index
`timescale 1ns/1ps
`default_nettype none
module regfile_model (
    input  wire logic [3:0]  firstSrcIdx,     // Index
    input  wire logic [3:0]  secondSrcIdx,    // Index
    input  wire logic [3:0]  accHighIdx,      // Index
    input  wire logic [3:0]  accLowIdx,       // Index
    output logic      [31:0] firstSourceReg,  // Value
    output logic      [31:0] secondSourceReg, // Value
    output logic      [31:0] accumulateReg,   // Value
    output logic      [31:0] accHighReg,      // Value
    output logic      [31:0] accLowReg        // Value
);
    // Loaded by the bench; entry 15 is never named, so no program counter is modelled
    logic [31:0] rf [0:15];
    assign firstSourceReg  = rf[firstSrcIdx];
    assign secondSourceReg = rf[secondSrcIdx];
    assign accumulateReg   = rf[accLowIdx];
    assign accHighReg      = rf[accHighIdx];
    assign accLowReg       = rf[accLowIdx];
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the halfword multiply-accumulate datapath
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        ref_clk = 0, nrst = 0, instValid = 0, satIn = 0;
    logic [31:0] instWord = 32'h0;
    logic [3:0]  nzcvIn = 4'h0;
    wire  [3:0]  firstSrcIdx, secondSrcIdx, accHighIdx, accLowIdx, wrLowIdx_q, wrHighIdx_q, nzcvOut;
    wire  [31:0] firstSourceReg, secondSourceReg, accumulateReg, accHighReg, accLowReg;
    wire  [31:0] resLow_q, resHigh_q;
    wire         isLongMac, isWordMac, wrLow_q, wrHigh_q, satOut_q, satWr_q, overflow_q, excReq;
    int          n_fail = 0, n_checks = 0, cyc = 0;
    halfword_mac_accumulate i_halfword_mac_accumulate (.*);
    regfile_model i_regfile_model (.*);
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail = n_fail + 1;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Result lands on the same edge that takes the request, one edge after it is driven
    task automatic issue(input logic [31:0] w, input logic [3:0] f, input logic q);
        @(posedge ref_clk);
        instValid <= 1'b1;
        instWord <= w;
        nzcvIn <= f;
        satIn <= q;
        @(posedge ref_clk);
        instValid <= 1'b0;
        #1;
    endtask
    task automatic long_case;
        logic signed [15:0] a, b;
        logic signed [63:0] e;
        for (int k = 0; k < 4; k++) begin
            a = k[0] ? 16'h8000 : 16'h7fff;
            b = k[1] ? 16'h7fff : 16'h8000;
            e = a * b;
            e = e + {32'h0000_0005, 32'hffff_fff0};
            issue({4'he, 8'h14, 4'h2, 4'h1, 4'h4, 1'b1, k[1], k[0], 1'b0, 4'h3}, 4'h0, 1'b0);
            chk("long result", e, {resHigh_q, resLow_q});
            chk("long strobes", 64'h3, {wrHigh_q, wrLow_q});
            chk("long indices", 64'h21, {wrHighIdx_q, wrLowIdx_q});
            chk("long decode", 64'h2, {isLongMac, isWordMac});
        end
    endtask
    task automatic word_case;
        logic signed [15:0] b;
        logic signed [47:0] p;
        logic        [31:0] acc;
        logic        [32:0] s;
        for (int k = 0; k < 4; k++) begin
            b = k[0] ? 16'h7fff : 16'h8000;
            acc = k[1] ? 32'h7fff_ff00 : 32'h0000_0100;
            p = 32'sh8000_7fff * b;
            s = {acc[31], acc} + {p[47], p[47:16]};
            i_regfile_model.rf[6] = acc;
            issue({4'he, 8'h12, 4'h5, 4'h6, 4'h4, 1'b1, k[0], 2'b00, 4'h3}, 4'h0, k[0]);
            chk("word result", s[31:0], resHigh_q);
            chk("overflow", s[32] ^ s[31], overflow_q);
            chk("sat flag", (s[32] ^ s[31]) | k[0], satOut_q);
            chk("word strobes", 64'h2, {wrHigh_q, wrLow_q});
            chk("word dest index", 64'h5, wrHighIdx_q);
            chk("word decode", 64'h1, {isLongMac, isWordMac});
        end
    endtask
    task automatic refused_case;
        logic [31:0] w [4] = '{32'he142_1493, 32'hf142_1483, 32'h0142_1483, 32'he142_1403};
        for (int k = 0; k < 4; k++) begin
            issue(w[k], 4'hb, 1'b1);
            chk("refused strobes", 64'h0, {wrHigh_q, wrLow_q, satWr_q});
            chk("flags", {nzcvIn, 1'b0}, {nzcvOut, excReq});
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        i_regfile_model.rf[1] = 32'hffff_fff0;
        i_regfile_model.rf[2] = 32'h0000_0005;
        i_regfile_model.rf[3] = 32'h8000_7fff;
        i_regfile_model.rf[4] = 32'h7fff_8000;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        long_case();
        word_case();
        refused_case();
        tally_and_finish();
    end
endmodule
bind halfword_mac_accumulate mac_props i_mac_props (.*);
`default_nettype wire
